/* File: core/cpu_board_glue_defines.vh */
`ifndef CPU_BOARD_GLUE_DEFINES_VH
`define CPU_BOARD_GLUE_DEFINES_VH

// Register byte offsets
`define REG_CONFIG        8'h00
`define REG_JUMP          8'h04
`define REG_STATUS        8'h08

// Configuration register fields
`define CFG_BASE_LSB      0
`define CFG_BASE_MSB      2
`define CFG_EN_ROM2       3
`define CFG_EN_ROM3       4
`define CFG_EN_ROM1_RAM   5
`define CFG_CLK_JUMPER    6
`define CFG_WIDTH         7
// Delivered setting: block at 8000, only first ROM and RAM enabled, jumper open (4 MHz)
`define CFG_RESET         7'h24

// Jump register: upper byte of the post-reset target
`define JUMP_RESET        8'hFC

// Offsets inside the memory block, taken from address bits 12..11
`define SLOT_NONE         2'h0
`define SLOT_ROM2         2'h1
`define SLOT_ROM3         2'h2
`define SLOT_TOP          2'h3

// Region codes reported in status
`define REGION_NONE       3'h0
`define REGION_ROM2       3'h1
`define REGION_ROM3       3'h2
`define REGION_RAM        3'h3
`define REGION_ROM1       3'h4

// Forced jump: opcode then low byte then high byte
`define JUMP_OPCODE       8'hC3
`define JUMP_LOW_BYTE     8'h00

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif

/* File: core/cpu_board_memory_decode_glue.v */
// Contract
// - Three base jumpers set address bits 15..13 of the on-board block.
// - Block map: ROM2 +0800, ROM3 +1000, RAM +1800, ROM1 +1C00, lowest 2K unused.
// - Only the upper 1K of the first ROM is used, at the block's top 1K.
// - RAM chip one holds bits 0,7,6,5; chip two holds bits 4,3,2,1.
// - Enables: one for ROM2, one for ROM3, one for ROM1 and RAM together.
// - Reads of enabled on-board addresses return on-board data, external reads are blocked.
// - Writes to enabled on-board addresses update on-board memory and go external too.
// - At 4 MHz every on-board access gets exactly one wait state.
// - Clock jumper connected selects 2 MHz, disconnected selects 4 MHz.
// - Rate indicator line is high at 4 MHz, low at 2 MHz.
// - After reset execution jumps to jumper byte as high address, low byte zero.
// - Delivered post-reset jump target is FC00.
// - Processor refresh strobe is forwarded onto its own bus line.
// - Processor memory request strobe is forwarded onto the bus.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_board_glue_defines.vh"

module cpu_board_memory_decode_glue #(
	parameter RAM_DEPTH = 1024                       // Words per RAM chip
) (
	input  wire        aclk,                         // System clock, 125 MHz
	input  wire        aresetn,                      // Synchronous reset, active low
	input  wire [7:0]  s_axi_awaddr,                 // Write address
	input  wire        s_axi_awvalid,                // Write address valid
	output wire        s_axi_awready,                // Write address ready
	input  wire [31:0] s_axi_wdata,                  // Write data
	input  wire [3:0]  s_axi_wstrb,                  // Write byte strobes
	input  wire        s_axi_wvalid,                 // Write data valid
	output wire        s_axi_wready,                 // Write data ready
	output reg  [1:0]  s_axi_bresp,                  // Write response
	output reg         s_axi_bvalid,                 // Write response valid
	input  wire        s_axi_bready,                 // Write response ready
	input  wire [7:0]  s_axi_araddr,                 // Read address
	input  wire        s_axi_arvalid,                // Read address valid
	output wire        s_axi_arready,                // Read address ready
	output reg  [31:0] s_axi_rdata,                  // Read data
	output reg  [1:0]  s_axi_rresp,                  // Read response
	output reg         s_axi_rvalid,                 // Read data valid
	input  wire        s_axi_rready,                 // Read data ready
	input  wire [15:0] cpu_addr,                     // Processor address
	input  wire [7:0]  cpu_data_out,                 // Processor write data
	input  wire        cpu_memory_request_strobe_n,  // Processor memory request, low active
	input  wire        cpu_refresh_strobe_n,         // Processor refresh, low active
	input  wire        cpu_rd_n,                     // Processor read, low active
	input  wire        cpu_wr_n,                     // Processor write, low active
	input  wire        cpu_clk_tick,                 // One-cycle pulse per processor clock rise
	output reg  [7:0]  cpu_data_in,                  // Read data to processor
	output reg         cpu_wait_n,                   // Wait request, low active
	output wire        clk_select_2mhz,              // Steers the processor clock source
	input  wire [7:0]  bus_data_in,                  // Data from external bus
	output reg         bus_read_inhibit,             // Blocks external read drivers
	output wire        bus_memory_request_strobe_n,  // Memory request on bus, low active
	output wire        bus_refresh_strobe_n,         // Refresh on bus, low active
	output wire        bus_wr_n,                     // Write strobe on bus, low active
	output wire        clock_rate_indicator,         // High at 4 MHz
	output reg  [2:0]  rom_select,                   // ROM1..ROM3 chip selects, one hot
	output reg  [10:0] rom_addr,                     // Address into selected ROM
	input  wire [7:0]  rom_data                      // Data from selected ROM
);

	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_HELD = 3'b100;

	reg  [`CFG_WIDTH-1:0] config_r;
	// Jumpers survive a reset, so only power-up loads the delivered byte
	reg  [7:0]            jump_r = `JUMP_RESET;
	reg                   rd_d_r;
	reg  [1:0]            jump_step_r;
	reg  [2:0]            state_r;
	reg  [2:0]            state_nxt;
	reg  [2:0]            last_region_r;
	reg                   memory_request_strobe_d_r;
	reg  [3:0]            ram_lo [0:RAM_DEPTH-1];
	reg  [3:0]            ram_hi [0:RAM_DEPTH-1];
	reg  [7:0]            awaddr_r;
	reg  [31:0]           wdata_r;
	reg  [3:0]            wstrb_r;
	reg                   aw_have_r;
	reg                   w_have_r;

	wire       active_req;
	wire       in_block;
	wire [1:0] slot;
	wire       hit_rom2;
	wire       hit_rom3;
	wire       hit_ram;
	wire       hit_rom1;
	wire       hit_any;
	wire       rate_4mhz;
	wire       cycle_start;
	wire       cycle_end;
	wire       jump_pending;
	wire [7:0] ram_byte;
	wire [9:0] ram_index;
	wire       wr_go;

	assign bus_memory_request_strobe_n = cpu_memory_request_strobe_n;
	assign bus_refresh_strobe_n        = cpu_refresh_strobe_n;
	assign bus_wr_n                    = cpu_wr_n;

	// Refresh puts the refresh counter on the address bus; it must not pick a chip
	assign active_req = !cpu_memory_request_strobe_n && cpu_refresh_strobe_n;
	assign in_block   = cpu_addr[15:13] == config_r[`CFG_BASE_MSB:`CFG_BASE_LSB];
	assign slot       = cpu_addr[12:11];
	assign hit_rom2   = active_req && in_block && slot == `SLOT_ROM2
		&& config_r[`CFG_EN_ROM2];
	assign hit_rom3   = active_req && in_block && slot == `SLOT_ROM3
		&& config_r[`CFG_EN_ROM3];
	assign hit_ram    = active_req && in_block && slot == `SLOT_TOP && !cpu_addr[10]
		&& config_r[`CFG_EN_ROM1_RAM];
	assign hit_rom1   = active_req && in_block && slot == `SLOT_TOP && cpu_addr[10]
		&& config_r[`CFG_EN_ROM1_RAM];
	assign hit_any    = hit_rom2 || hit_rom3 || hit_ram || hit_rom1;

	assign rate_4mhz            = !config_r[`CFG_CLK_JUMPER];
	assign clk_select_2mhz      = config_r[`CFG_CLK_JUMPER];
	assign clock_rate_indicator = rate_4mhz;

	assign cycle_start = active_req && !memory_request_strobe_d_r;
	assign cycle_end   = cpu_memory_request_strobe_n && memory_request_strobe_d_r;

	assign ram_index = cpu_addr[9:0];
	assign ram_byte  = {ram_lo[ram_index][2], ram_lo[ram_index][1], ram_lo[ram_index][0],
		ram_hi[ram_index][3], ram_hi[ram_index][2], ram_hi[ram_index][1],
		ram_hi[ram_index][0], ram_lo[ram_index][3]};
	assign jump_pending = jump_step_r != 2'd3;

	always @(posedge aclk) begin
		if (!aresetn) begin
			memory_request_strobe_d_r <= 1'b0;
			rd_d_r   <= 1'b0;
		end else begin
			memory_request_strobe_d_r <= !cpu_memory_request_strobe_n;
			rd_d_r   <= !cpu_rd_n;
		end
	end

	// Chip one keeps D0,D7,D6,D5 and chip two D4,D3,D2,D1 in nibble bits 3..0
	always @(posedge aclk) begin
		if (hit_ram && !cpu_wr_n) begin
			ram_lo[ram_index] <= {cpu_data_out[0], cpu_data_out[7:5]};
			ram_hi[ram_index] <= cpu_data_out[4:1];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rom_select <= 3'h0;
			rom_addr   <= 11'h000;
		end else begin
			rom_select <= {hit_rom3, hit_rom2, hit_rom1};
			rom_addr   <= hit_rom1 ? {1'b1, cpu_addr[9:0]} : cpu_addr[10:0];
		end
	end

	// Read path and forced jump; the first three reads after reset fetch JP target
	always @(posedge aclk) begin
		if (!aresetn) begin
			cpu_data_in      <= 8'h00;
			bus_read_inhibit <= 1'b0;
			jump_step_r      <= 2'd0;
		end else begin
			bus_read_inhibit <= active_req && (hit_any || jump_pending) && !cpu_rd_n;
			if (jump_pending) begin
				case (jump_step_r)
				2'd0:    cpu_data_in <= `JUMP_OPCODE;
				2'd1:    cpu_data_in <= `JUMP_LOW_BYTE;
				default: cpu_data_in <= jump_r;
				endcase
				// Read strobe rises with the request, so last cycle's read is used
				if (cycle_end && rd_d_r)
					jump_step_r <= jump_step_r + 2'd1;
			end else if (hit_ram) begin
				cpu_data_in <= ram_byte;
			end else if (hit_rom1 || hit_rom2 || hit_rom3) begin
				cpu_data_in <= rom_data;
			end else begin
				cpu_data_in <= bus_data_in;
			end
		end
	end

	// Wait: hold until one processor clock rise has passed, then free the cycle
	always @* begin
		case (state_r)
		ST_IDLE: state_nxt = (cycle_start && hit_any && rate_4mhz) ? ST_WAIT : ST_IDLE;
		ST_WAIT: state_nxt = cpu_clk_tick ? ST_HELD : ST_WAIT;
		ST_HELD: state_nxt = cpu_memory_request_strobe_n ? ST_IDLE : ST_HELD;
		default: state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r       <= ST_IDLE;
			cpu_wait_n    <= 1'b1;
			last_region_r <= `REGION_NONE;
		end else begin
			state_r    <= state_nxt;
			cpu_wait_n <= !(state_nxt == ST_WAIT);
			if (cycle_start && hit_any)
				last_region_r <= hit_ram ? `REGION_RAM : hit_rom1 ? `REGION_ROM1 :
					hit_rom2 ? `REGION_ROM2 : `REGION_ROM3;
		end
	end

	// AXI4-Lite slave: address and data taken in either order, one response
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_have_r && w_have_r && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r    <= 1'b0;
			w_have_r     <= 1'b0;
			awaddr_r     <= 8'h00;
			wdata_r      <= 32'h0000_0000;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
			config_r     <= `CFG_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				case ({awaddr_r[7:2], 2'b00})
				`REG_CONFIG: if (wstrb_r[0])
					config_r <= wdata_r[`CFG_WIDTH-1:0];
				`REG_JUMP: if (wstrb_r[0])
					jump_r <= wdata_r[7:0];
				`REG_STATUS: ;
				default: s_axi_bresp <= `RESP_DECERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
			`REG_CONFIG: s_axi_rdata <= {25'h0, config_r};
			`REG_JUMP:   s_axi_rdata <= {24'h0, jump_r};
			`REG_STATUS: s_axi_rdata <= {26'h0, last_region_r, jump_pending,
				!cpu_wait_n, rate_4mhz};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `RESP_DECERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // cpu_board_memory_decode_glue
`default_nettype wire

/* File: dv/glue_props.sv */
`timescale 1ns/10ps
`default_nettype none
module glue_props (
	input wire logic        aclk,                        // Clock
	input wire logic        aresetn,                     // Reset, low active
	input wire logic        cpu_memory_request_strobe_n, // Cpu request
	input wire logic        cpu_refresh_strobe_n,        // Cpu refresh
	input wire logic        cpu_wr_n,                    // Cpu write
	input wire logic        cpu_wait_n,                  // Wait
	input wire logic        clk_select_2mhz,             // Slow clock
	input wire logic        bus_memory_request_strobe_n, // Bus request
	input wire logic        bus_refresh_strobe_n,        // Bus refresh
	input wire logic        bus_wr_n,                    // Bus write
	input wire logic        clock_rate_indicator,        // Rate line
	input wire logic [2:0]  rom_select,                  // ROM selects
	input wire logic [10:0] rom_addr                     // ROM address
);
	logic got_r;
	// Remembers that this request already waited, so a second wait stands out
	always @(posedge aclk)
		got_r <= aresetn && !cpu_memory_request_strobe_n && (got_r || !cpu_wait_n);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rate; clock_rate_indicator == !clk_select_2mhz; endproperty
	a_rate: assert property (p_rate) else $error("rate line wrong");
	property p_fwd; bus_refresh_strobe_n == cpu_refresh_strobe_n
		&& bus_memory_request_strobe_n == cpu_memory_request_strobe_n && bus_wr_n == cpu_wr_n;
	endproperty
	a_fwd: assert property (p_fwd) else $error("strobe not forwarded");
	property p_cause; $fell(cpu_wait_n) |-> clock_rate_indicator
		&& !$past(cpu_memory_request_strobe_n) && $past(cpu_refresh_strobe_n); endproperty
	a_cause: assert property (p_cause) else $error("wait without cause");
	property p_end; $fell(cpu_wait_n) |-> ##[1:6] cpu_wait_n; endproperty
	a_end: assert property (p_end) else $error("wait too long");
	property p_once; got_r && cpu_wait_n && !cpu_memory_request_strobe_n |=> cpu_wait_n;
	endproperty
	a_once: assert property (p_once) else $error("second wait");
	property p_slow; clk_select_2mhz && $past(clk_select_2mhz) |-> cpu_wait_n; endproperty
	a_slow: assert property (p_slow) else $error("wait at slow clock");
	property p_refresh_strobe; !cpu_refresh_strobe_n && !$past(cpu_refresh_strobe_n)
		|-> rom_select == 3'h0 && cpu_wait_n; endproperty
	a_refresh_strobe: assert property (p_refresh_strobe) else $error("refresh decoded");
	property p_hot; $onehot0(rom_select); endproperty
	a_hot: assert property (p_hot) else $error("two ROMs selected");
	property p_top; rom_select == 3'h1 |-> rom_addr[10]; endproperty
	a_top: assert property (p_top) else $error("lower ROM half used");
endmodule // glue_props
bind cpu_board_memory_decode_glue glue_props props_u (.*);
`default_nettype wire

/* File: dv/s100_card_model.sv */
`timescale 1ns/10ps
`default_nettype none
module s100_card_model (
	input wire logic        aclk,       // Clock
	input wire logic [15:0] addr,       // Bus address
	input wire logic [7:0]  wdata,      // Bus write data
	input wire logic        memory_request_strobe_n,     // Memory request
	input wire logic        rd_n,       // Read, gated by inhibit
	input wire logic        wr_n,       // Write
	input wire logic [2:0]  rom_select, // ROM socket selects
	input wire logic [10:0] rom_addr,   // ROM socket address
	output logic     [7:0]  bus_data,   // Card read data
	output logic     [7:0]  rom_data    // ROM socket data
);
	logic [7:0] mem [0:255];
	logic [7:0] spin;
	initial begin
		spin = 8'h00;
		for (int i = 0; i < 256; i++)
			mem[i] = i[7:0] ^ 8'h5A;
	end
	// Undriven lines toggle so a stale byte never passes
	always @(posedge aclk) begin
		spin <= ~spin;
		if (!memory_request_strobe_n && !wr_n)
			mem[addr[7:0]] <= wdata;
	end
	assign bus_data = (!memory_request_strobe_n && !rd_n) ? mem[addr[7:0]] : spin;
	assign rom_data = (|rom_select) ? {rom_select, rom_addr[4:0]} : spin;
endmodule // s100_card_model
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_board_glue_defines.vh"
module testbench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
	logic        s_axi_rvalid, cpu_memory_request_strobe_n, cpu_refresh_strobe_n, cpu_rd_n;
	logic        cpu_wr_n, cpu_clk_tick, cpu_wait_n, clk_select_2mhz, bus_read_inhibit, inh;
	logic        bus_memory_request_strobe_n, bus_refresh_strobe_n, bus_wr_n, wrb;
	logic        clock_rate_indicator;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, cpu_data_out, cpu_data_in, bus_data_in, rom_data, q;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [15:0] cpu_addr, a;
	logic [10:0] rom_addr, ra;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  rom_select, sel, s;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r, tc;
	int          error_cnt, n_checks, cyc, w;
	localparam logic [63:0] ADR = 64'hE805F009FC03E003;
	localparam logic [11:0] SEL = 12'h508;
	localparam logic [23:0] JSEQ = {`JUMP_OPCODE, `JUMP_LOW_BYTE, 8'hFC};
	cpu_board_memory_decode_glue dut_u (.*);
	s100_card_model card_u (.aclk, .addr(cpu_addr), .wdata(cpu_data_out),
		.memory_request_strobe_n(bus_memory_request_strobe_n), .rd_n(cpu_rd_n | bus_read_inhibit),
		.wr_n(bus_wr_n), .rom_select, .rom_addr, .bus_data(bus_data_in), .rom_data);
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		tc <= tc + 2'h1;
		cpu_clk_tick <= (tc == 2'h3);
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Ready and answer are taken at the rising edge, before that edge's updates land
	task automatic axi(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		logic aw, wd, ar, ok;
		@(posedge aclk);
		{aw, wd, ar, ok} = {wr, wr, !wr, 1'b0};
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {ad, ad, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {wr, wr, !wr};
		{s_axi_bready, s_axi_rready} <= {wr, !wr};
		while (!ok) begin
			@(posedge aclk);
			ok = wr ? s_axi_bvalid : s_axi_rvalid;
			{rd, r} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
			{aw, wd, ar} = {aw && !s_axi_awready, wd && !s_axi_wready, ar && !s_axi_arready};
			{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {aw, wd, ar};
		end
		{s_axi_bready, s_axi_rready} <= 2'b00;
	endtask
	task automatic cpu(input logic [15:0] ad, input logic wr, input logic rf, input logic [7:0] d);
		@(posedge aclk);
		{cpu_addr, cpu_data_out} <= {ad, d};
		{cpu_memory_request_strobe_n, cpu_refresh_strobe_n} <= {1'b0, !rf};
		{cpu_rd_n, cpu_wr_n} <= {wr || rf, !wr};
		w = 0;
		@(posedge aclk);
		#1;
		while (cpu_wait_n !== 1'b1 && w < 20) begin
			w++;
			@(posedge aclk);
			#1;
		end
		repeat (2) @(posedge aclk);
		#1;
		{q, sel, ra, inh, wrb} = {cpu_data_in, rom_select, rom_addr, bus_read_inhibit, bus_wr_n};
		@(posedge aclk);
		{cpu_memory_request_strobe_n, cpu_refresh_strobe_n, cpu_rd_n, cpu_wr_n} <= 4'hF;
	endtask
	task final_report();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{cpu_memory_request_strobe_n, cpu_refresh_strobe_n, cpu_rd_n, cpu_wr_n} = 4'hF;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, cpu_addr, cpu_data_out, tc} = '0;
		{s_axi_wstrb, aresetn, cpu_clk_tick, error_cnt, n_checks, cyc} = {4'hF, 98'h0};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk(clock_rate_indicator, 1);
		for (int i = 0; i < 3; i++) begin
			cpu(16'h0000, 0, 0, 8'h00);
			chk(q, JSEQ[23 - 8 * i -: 8]);
		end
		axi(0, `REG_CONFIG, 0);
		chk(rd, `CFG_RESET);
		cpu(16'h9C05, 0, 0, 0);
		chk({sel, inh, q, w != 0}, {3'h1, 1'b1, 3'h1, 5'h05, 1'b1});
		axi(1, `REG_CONFIG, 32'h3F);
		chk(r, `RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			{a, s} = {ADR[63 - 16 * i -: 16], SEL[11 - 3 * i -: 3]};
			cpu(a, 0, 0, 0);
			chk({sel, inh, w != 0}, {s, s != 0, s != 0});
			chk(q, (s != 0) ? {s, a[4:0]} : a[7:0] ^ 8'h5A);
			chk(ra, a[10:0]);
		end
		cpu(16'hF812, 1, 0, 8'hA6);
		chk(wrb, 0);
		cpu(16'hF812, 0, 0, 0);
		chk({inh, q}, {1'b1, 8'hA6});
		axi(1, `REG_CONFIG, 32'h1F);
		cpu(16'hF812, 0, 0, 0);
		chk({inh, q}, {1'b0, 8'hA6});
		axi(1, `REG_CONFIG, 32'h37);
		cpu(16'hE805, 0, 0, 0);
		chk({sel, q}, {3'h0, 8'h5F});
		axi(1, `REG_CONFIG, 32'h3F);
		cpu(16'hFC03, 0, 1, 0);
		chk({sel, w != 0}, 4'h0);
		axi(1, `REG_CONFIG, 32'h7F);
		chk({clock_rate_indicator, clk_select_2mhz}, 2'b01);
		cpu(16'hFC03, 0, 0, 0);
		chk({w != 0, q}, {1'b0, 8'h23});
		axi(0, `REG_STATUS, 0);
		chk(rd, {`REGION_ROM1, 3'h0});
		axi(1, 8'h0C, 32'h1);
		chk(r, `RESP_DECERR);
		axi(0, 8'h10, 0);
		chk(r, `RESP_DECERR);
		axi(0, `REG_CONFIG, 0);
		chk(rd, 32'h7F);
		axi(1, `REG_JUMP, 32'hA5);
		chk(r, `RESP_OKAY);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk({clock_rate_indicator, cpu_wait_n}, 2'b11);
		for (int i = 0; i < 3; i++) begin
			cpu(16'h0000, 0, 0, 8'h00);
			chk(q, (i == 2) ? 8'hA5 : JSEQ[23 - 8 * i -: 8]);
		end
		axi(0, `REG_JUMP, 0);
		chk(rd, 32'hA5);
		final_report();
	end
endmodule // testbench
`default_nettype wire
